// >>> rtl/gcl_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcl_regs.svh"
module gcl_config_regs
  import gcl_pkg::*;
#(
  parameter logic [2:0] CHIP_ID  = 3'h5,  // arbitrary identity value
  parameter logic [4:0] CHIP_REV = 5'h01  // arbitrary revision value
) (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       cfg_wr_i,
  input  wire logic [7:0] cfg_idx_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  input  wire logic [2:0] dev_activate_i,
  input  wire logic       wake_event_i,
  output logic      [3:0] io_wait_states_o,
  output logic            soft_reset_trigger_o,
  output logic      [2:0] dev_enable_o,
  output logic      [2:0] dev_runtime_ok_o,
  output logic            pin_port_config_lock_o,
  output logic            wake_event_output_o,
  output logic            wake_event_output_oe_o,
  output logic            wake_event_pullup_en_o,
  output logic            fan2_speed_input_sel_o,
  output logic            fan1_speed_input_sel_o,
  output logic            ddc_or_port_pin_select_o,
  output logic            clock_gen_run_o,
  output logic            clock_gen_valid_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_n_q;

  // async assert, two-stage synchronous release
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic       mux_lock_q, port_lock_q, glob_en_q, soft_reset_trigger_q;
  logic [1:0] wait_code_q;
  logic       pol_q, drv_q, tach2_q, tach1_q, ddc_q;
  logic       fd_lock_q, ser_off_q, par_off_q, fdc_off_q;
  logic [1:0] scratch_q;
  logic       ck_en_q, ck_valid_q;
  logic [7:0] ck_cnt_q;
  gcl_ck_state_t ck_st_q;

  // reset images; single fields are picked from them so reset values live in one place
  localparam logic [7:0] CFG1_RST = `GCL_CFG1_RST;
  localparam logic [7:0] CFG2_RST = `GCL_CFG2_RST;
  localparam logic [7:0] FDIS_RST = `GCL_FDIS_RST;
  localparam logic [7:0] CLK_RST  = `GCL_CLK_RST;

  logic wr1, wr2, wr6, wr9;
  assign wr1 = cfg_wr_i && (cfg_idx_i == `GCL_IDX_CFG1);
  assign wr2 = cfg_wr_i && (cfg_idx_i == `GCL_IDX_CFG2);
  assign wr6 = cfg_wr_i && (cfg_idx_i == `GCL_IDX_FDIS);
  assign wr9 = cfg_wr_i && (cfg_idx_i == `GCL_IDX_CLK);

  // system_config_one; fixed bits are never stored, writes to them ignored
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_lock_q  <= CFG1_RST[`GCL_C1_MUXLOCK];
      port_lock_q <= CFG1_RST[`GCL_C1_PORTLOCK];
      wait_code_q <= CFG1_RST[`GCL_C1_WAIT_HI:`GCL_C1_WAIT_LO];
      glob_en_q   <= CFG1_RST[`GCL_C1_GLOBAL_DEVICE_ENABLE];
    end else if (wr1) begin
      if (cfg_wdata_i[`GCL_C1_MUXLOCK]) begin
        mux_lock_q <= 1'b1;
      end
      if (cfg_wdata_i[`GCL_C1_PORTLOCK]) begin
        port_lock_q <= 1'b1;
      end
      if (!mux_lock_q) begin
        wait_code_q <= cfg_wdata_i[`GCL_C1_WAIT_HI:`GCL_C1_WAIT_LO];
      end
      if (!fd_lock_q) begin
        glob_en_q <= cfg_wdata_i[`GCL_C1_GLOBAL_DEVICE_ENABLE];
      end
    end
  end

  // soft reset is a one-cycle strobe, not held so reads see zero
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_reset_trigger_q <= CFG1_RST[`GCL_C1_SOFT_RESET_TRIGGER];
    end else begin
      soft_reset_trigger_q <= wr1 && cfg_wdata_i[`GCL_C1_SOFT_RESET_TRIGGER];
    end
  end

  // system_config_two, frozen as a whole by the mux lock
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pol_q   <= CFG2_RST[`GCL_C2_POL];
      drv_q   <= CFG2_RST[`GCL_C2_DRV];
      tach2_q <= CFG2_RST[`GCL_C2_TACH2];
      tach1_q <= CFG2_RST[`GCL_C2_TACH1];
      ddc_q   <= CFG2_RST[`GCL_C2_DDC];
    end else if (wr2 && !mux_lock_q) begin
      pol_q   <= cfg_wdata_i[`GCL_C2_POL];
      drv_q   <= cfg_wdata_i[`GCL_C2_DRV];
      tach2_q <= cfg_wdata_i[`GCL_C2_TACH2];
      tach1_q <= cfg_wdata_i[`GCL_C2_TACH1];
      ddc_q   <= cfg_wdata_i[`GCL_C2_DDC];
    end
  end

  // fast_disable_config; scratch bits ignore the lock
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fd_lock_q <= FDIS_RST[`GCL_FD_LOCK];
      ser_off_q <= FDIS_RST[`GCL_FD_SER];
      par_off_q <= FDIS_RST[`GCL_FD_PAR];
      fdc_off_q <= FDIS_RST[`GCL_FD_FDC];
      scratch_q <= FDIS_RST[`GCL_FD_SCR_HI:`GCL_FD_SCR_LO];
    end else if (wr6) begin
      scratch_q <= cfg_wdata_i[`GCL_FD_SCR_HI:`GCL_FD_SCR_LO];
      if (cfg_wdata_i[`GCL_FD_LOCK]) begin
        fd_lock_q <= 1'b1;
      end
      if (!fd_lock_q) begin
        ser_off_q <= cfg_wdata_i[`GCL_FD_SER];
        par_off_q <= cfg_wdata_i[`GCL_FD_PAR];
        fdc_off_q <= cfg_wdata_i[`GCL_FD_FDC];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock generator
  // ----------------------------------------------------------------
  // enable is write-one-set and is the only writable bit, so it locks itself
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ck_en_q <= CLK_RST[`GCL_CK_EN];
    end else if (wr9 && cfg_wdata_i[`GCL_CK_EN]) begin
      ck_en_q <= 1'b1;
    end
  end

  // output stays frozen through a settle count before valid rises
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ck_st_q    <= GCL_CK_OFF;
      ck_cnt_q   <= 8'h00;
      ck_valid_q <= CLK_RST[`GCL_CK_VALID];
    end else begin
      case (ck_st_q)
        GCL_CK_OFF: begin
          if (ck_en_q) begin
            ck_st_q <= GCL_CK_SETTLE;
          end
        end
        GCL_CK_SETTLE: begin
          ck_cnt_q <= ck_cnt_q + 8'h01;
          if (ck_cnt_q == `GCL_CK_SETTLE) begin
            ck_st_q    <= GCL_CK_RUN;
            ck_valid_q <= 1'b1;
          end
        end
        GCL_CK_RUN: begin
          ck_valid_q <= 1'b1;
        end
        default: begin
          ck_st_q    <= GCL_CK_OFF;
          ck_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // wait count decode
  always_comb begin
    case (wait_code_q)
      2'b00:   io_wait_states_o = `GCL_WAIT_0;
      2'b01:   io_wait_states_o = `GCL_WAIT_1;
      2'b10:   io_wait_states_o = `GCL_WAIT_2;
      default: io_wait_states_o = `GCL_WAIT_3;
    endcase
  end

  logic [2:0] off_vec;
  assign off_vec = {ser_off_q, par_off_q, fdc_off_q};

  // global enable and force-off override per-device activation
  assign dev_enable_o     = dev_activate_i & ~off_vec & {3{glob_en_q}};
  assign dev_runtime_ok_o = dev_enable_o;

  assign soft_reset_trigger_o   = soft_reset_trigger_q;
  assign pin_port_config_lock_o = port_lock_q;

  // open-drain drives only the low level; push-pull always drives
  logic wake_lvl;
  assign wake_lvl               = pol_q ? wake_event_i : ~wake_event_i;
  assign wake_event_output_o    = wake_lvl;
  assign wake_event_output_oe_o = drv_q | ~wake_lvl;
  assign wake_event_pullup_en_o = ~drv_q;

  assign fan2_speed_input_sel_o   = tach2_q;
  assign fan1_speed_input_sel_o   = tach1_q;
  assign ddc_or_port_pin_select_o = ddc_q;
  assign clock_gen_run_o          = ck_en_q;
  assign clock_gen_valid_o        = ck_valid_q;

  // read mux; reserved and unmapped indexes read zero
  always_comb begin
    cfg_rdata_o = 8'h00;
    case (cfg_idx_i)
      `GCL_IDX_CFG1: cfg_rdata_o = {mux_lock_q, port_lock_q, `GCL_C1_FIXED,
                                    wait_code_q, 1'b0, glob_en_q};
      `GCL_IDX_CFG2: cfg_rdata_o = {pol_q, drv_q, tach2_q, tach1_q, 3'h0, ddc_q};
      `GCL_IDX_FDIS: cfg_rdata_o = {fd_lock_q, scratch_q, 1'b0, ser_off_q, 1'b0,
                                    par_off_q, fdc_off_q};
      `GCL_IDX_REVID: cfg_rdata_o = {CHIP_ID, CHIP_REV};
      `GCL_IDX_CLK:  cfg_rdata_o = {ck_en_q, 2'b00, ck_valid_q, 4'h0};
      default:       cfg_rdata_o = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_ck_start;
    !ck_en_q ##1 ck_en_q;
  endsequence

  sequence s_soft_reset_trigger_req;
    wr1 && cfg_wdata_i[`GCL_C1_SOFT_RESET_TRIGGER];
  endsequence

  chk_mux_lock_freeze: assert property (
    mux_lock_q && wr2 |=> $stable({pol_q, drv_q, tach2_q, tach1_q, ddc_q}))
    else $error("config two changed under mux lock");
  chk_lock_sticky: assert property (
    (!$past(mux_lock_q) || mux_lock_q) && (!$past(port_lock_q) || port_lock_q) &&
    (!$past(fd_lock_q) || fd_lock_q) && (!$past(ck_en_q) || ck_en_q))
    else $error("lock bit cleared without reset");
  chk_port_lock_out: assert property (
    wr1 && cfg_wdata_i[`GCL_C1_PORTLOCK] |=> pin_port_config_lock_o)
    else $error("port lock output not raised");
  chk_wait_decode: assert property (
    wait_code_q == 2'b11 |-> io_wait_states_o == `GCL_WAIT_3)
    else $error("wait decode wrong");
  // a second request right behind the first legally stretches the strobe
  chk_soft_reset_trigger_pulse: assert property (
    s_soft_reset_trigger_req ##1 !(wr1 && cfg_wdata_i[`GCL_C1_SOFT_RESET_TRIGGER])
      |-> soft_reset_trigger_o ##1 !soft_reset_trigger_o)
    else $error("soft reset pulse wrong");
  chk_soft_reset_trigger_no_req: assert property (
    !$past(wr1 && cfg_wdata_i[`GCL_C1_SOFT_RESET_TRIGGER]) |-> !soft_reset_trigger_o)
    else $error("soft reset pulse without a request");
  chk_glob_disable: assert property (
    !glob_en_q |-> dev_enable_o == 3'b000)
    else $error("device enabled while global off");
  chk_fd_lock_freeze: assert property (
    fd_lock_q && (wr6 || wr1) |=> $stable({ser_off_q, par_off_q, fdc_off_q, glob_en_q}))
    else $error("fast disable changed under lock");
  chk_force_off: assert property (
    (dev_enable_o & off_vec) == 3'b000)
    else $error("module enabled while forced off");
  chk_ck_valid_delay: assert property (
    s_ck_start |-> !clock_gen_valid_o [*8])
    else $error("clock valid too early");
  chk_ck_start_run: assert property (
    wr9 && cfg_wdata_i[`GCL_CK_EN] |=> clock_gen_run_o)
    else $error("clock generator not started");
  chk_valid_needs_run: assert property (
    clock_gen_valid_o |-> clock_gen_run_o)
    else $error("clock valid without generator enable");
  chk_wake_open_drain: assert property (
    !drv_q |-> wake_event_pullup_en_o && !(wake_event_output_oe_o && wake_event_output_o))
    else $error("open-drain wake pin drove high");
endmodule : gcl_config_regs
`default_nettype wire

// >>> rtl/gcl_regs.svh
`ifndef GCL_REGS_SVH
`define GCL_REGS_SVH
// register indexes in the configuration space
`define GCL_IDX_CFG1        8'h21
`define GCL_IDX_CFG2        8'h22
`define GCL_IDX_FDIS        8'h26
`define GCL_IDX_REVID       8'h27
`define GCL_IDX_CLK         8'h29
// reset values
`define GCL_CFG1_RST        8'h11
`define GCL_CFG2_RST        8'h00
`define GCL_FDIS_RST        8'h00
`define GCL_CLK_RST         8'h00
// system_config_one fields
`define GCL_C1_MUXLOCK      7
`define GCL_C1_PORTLOCK     6
`define GCL_C1_FIXED        2'b01
`define GCL_C1_WAIT_HI      3
`define GCL_C1_WAIT_LO      2
`define GCL_C1_SOFT_RESET_TRIGGER        1
`define GCL_C1_GLOBAL_DEVICE_ENABLE       0
// system_config_two fields
`define GCL_C2_POL          7
`define GCL_C2_DRV          6
`define GCL_C2_TACH2        5
`define GCL_C2_TACH1        4
`define GCL_C2_DDC          0
// fast_disable_config fields
`define GCL_FD_LOCK         7
`define GCL_FD_SCR_HI       6
`define GCL_FD_SCR_LO       5
`define GCL_FD_SER          3
`define GCL_FD_PAR          1
`define GCL_FD_FDC          0
// clock_gen_control fields
`define GCL_CK_EN           7
`define GCL_CK_VALID        4
// wait state counts per code
`define GCL_WAIT_0          4'h0
`define GCL_WAIT_1          4'h2
`define GCL_WAIT_2          4'h6
`define GCL_WAIT_3          4'hc
// final settle count value; valid rises 65 cycles after the generator enable is set
`define GCL_CK_SETTLE       8'h3f
`endif

// >>> rtl/gcl_pkg.sv
`default_nettype none
package gcl_pkg;
  // clock generator bring-up states
  typedef enum logic [2:0] {
    GCL_CK_OFF    = 3'b001,
    GCL_CK_SETTLE = 3'b010,
    GCL_CK_RUN    = 3'b100
  } gcl_ck_state_t;
endpackage : gcl_pkg
`default_nettype wire

// >>> dv/gcl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host issuing configuration cycles
// ----
module gcl_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       valid_i,
  output var  logic       wr_o,
  output var  logic [7:0] idx_o,
  output var  logic [7:0] wdata_o
);
  // quiet bus until the first request
  initial begin
    wr_o = 1'b0;
    idx_o = 8'h00;
    wdata_o = 8'h00;
  end
  // write held over one edge; released lines show the inverse, not stale data
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    idx_o = i;
    wdata_o = (i == 8'h21) ? {d[7:6], 2'b01, d[3:0]} : d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    idx_o = ~i;
    wdata_o = ~wdata_o;
  endtask : wr
  // read data is combinational, taken at the edge closing the cycle
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    idx_o = i;
    @(posedge clk_i);
    d = rdata_i;
    #1;
    idx_o = ~i;
  endtask : rd
  // users of the generated clock wait here; bounded so a dead clock shows
  task automatic wait_valid(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge clk_i);
      ok = valid_i;
    end
  endtask : wait_valid
endmodule : gcl_host_model
`default_nettype wire

// >>> dv/global_config_lock_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcl_regs.svh"
module global_config_lock_regs_bench;
  logic       clk_sys_i, arst_n_i, wake_event_i, g, lvl, ok;
  logic       cfg_wr, srst, plock, wo, woe, wpu, f2, f1, ddc, run, valid;
  logic [2:0] dev_activate_i, den, rok;
  logic [3:0] io_wait;
  logic [7:0] cfg_idx, cfg_wdata, rdata, d, r;
  integer     failures = 0;
  integer     num_checks = 0;
  integer     seed = 32'h916e;
  // ----
  // design and host
  // ----
  gcl_config_regs #(.CHIP_ID(3'h6), .CHIP_REV(5'h13)) gcl_config_regs_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr),
    .cfg_idx_i(cfg_idx), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(rdata),
    .dev_activate_i(dev_activate_i), .wake_event_i(wake_event_i),
    .io_wait_states_o(io_wait), .soft_reset_trigger_o(srst), .dev_enable_o(den),
    .dev_runtime_ok_o(rok), .pin_port_config_lock_o(plock), .wake_event_output_o(wo),
    .wake_event_output_oe_o(woe), .wake_event_pullup_en_o(wpu),
    .fan2_speed_input_sel_o(f2), .fan1_speed_input_sel_o(f1),
    .ddc_or_port_pin_select_o(ddc), .clock_gen_run_o(run), .clock_gen_valid_o(valid));
  gcl_host_model host_inst (.clk_i(clk_sys_i), .rdata_i(rdata), .valid_i(valid),
    .wr_o(cfg_wr), .idx_o(cfg_idx), .wdata_o(cfg_wdata));
  // 200 MHz
  always #2.5 clk_sys_i = ~clk_sys_i;
  // ----
  // helpers
  // ----
  function automatic logic [3:0] exp_wait(input logic [1:0] c);
    return (c == 2'd0) ? 4'h0 : (c == 2'd1) ? 4'h2 : (c == 2'd2) ? 4'h6 : 4'hc;
  endfunction : exp_wait
  function automatic logic [2:0] exp_en(input logic [2:0] a, input logic [7:0] fd,
                                        input logic e);
    return a & ~{fd[3], fd[1], fd[0]} & {3{e}};
  endfunction : exp_en
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_reg(input logic [7:0] i, input logic [7:0] exp);
    host_inst.rd(i, r);
    chk(r, exp);
  endtask : chk_reg
  task automatic do_reset;
    arst_n_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    #1 arst_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask : do_reset
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // whole run is a few hundred cycles; cut a hang well beyond that
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  // ----
  // scenarios
  // ----
  initial begin
    clk_sys_i = 1'b0;
    wake_event_i = 1'b0;
    dev_activate_i = 3'h7;
    do_reset();
    chk_reg(`GCL_IDX_CFG1, 8'h11);
    chk_reg(`GCL_IDX_FDIS, 8'h00);
    chk_reg(`GCL_IDX_CLK, 8'h00);
    host_inst.wr(`GCL_IDX_REVID, 8'h00);
    chk_reg(`GCL_IDX_REVID, 8'hd3);
    host_inst.wr(8'h23, 8'hff);
    chk_reg(8'h23, 8'h00);
    // every wait code
    for (int c = 0; c < 4; c++) begin
      host_inst.wr(`GCL_IDX_CFG1, {4'h0, 2'(c), 2'b01});
      chk(8'(io_wait), 8'(exp_wait(2'(c))));
    end
    host_inst.wr(`GCL_IDX_CFG1, 8'h03);
    chk(8'(srst), 8'h01);
    @(posedge clk_sys_i);
    #1;
    chk(8'(srst), 8'h00);
    chk_reg(`GCL_IDX_CFG1, 8'h11);
    // random pin mux and wake settings
    repeat (8) begin
      d = 8'($random(seed));
      wake_event_i = 1'($random(seed));
      host_inst.wr(`GCL_IDX_CFG2, d);
      chk_reg(`GCL_IDX_CFG2, d & 8'hf1);
      chk(8'({f2, f1, ddc}), 8'({d[5], d[4], d[0]}));
      lvl = d[7] ? wake_event_i : ~wake_event_i;
      chk(8'({wpu, woe, woe & wo}), 8'({~d[6], d[6] | ~lvl, lvl & d[6]}));
    end
    // random force-off, global enable and activation
    repeat (6) begin
      d = 8'($random(seed)) & 8'h7f;
      g = 1'($random(seed));
      dev_activate_i = 3'($random(seed));
      host_inst.wr(`GCL_IDX_FDIS, d);
      host_inst.wr(`GCL_IDX_CFG1, {7'h08, g});
      chk(8'(den), 8'(exp_en(dev_activate_i, d, g)));
      chk(8'(rok), 8'(exp_en(dev_activate_i, d, g)));
      chk_reg(`GCL_IDX_FDIS, d & 8'h6b);
    end
    // fast disable lock set together with all force-offs
    host_inst.wr(`GCL_IDX_CFG1, 8'h11);
    host_inst.wr(`GCL_IDX_FDIS, 8'h8b);
    host_inst.wr(`GCL_IDX_FDIS, 8'h60);
    chk_reg(`GCL_IDX_FDIS, 8'heb);
    chk(8'(den), 8'h00);
    host_inst.wr(`GCL_IDX_CFG1, 8'h10);
    chk_reg(`GCL_IDX_CFG1, 8'h11);
    // mux lock: wait field and second register frozen, others still open
    host_inst.wr(`GCL_IDX_CFG2, 8'h00);
    host_inst.wr(`GCL_IDX_CFG1, 8'h85);
    host_inst.wr(`GCL_IDX_CFG2, 8'hf1);
    host_inst.wr(`GCL_IDX_CFG1, 8'h4f);
    chk(8'(srst), 8'h01);
    chk_reg(`GCL_IDX_CFG2, 8'h00);
    chk_reg(`GCL_IDX_CFG1, 8'hd5);
    chk(8'({plock, io_wait}), 8'h12);
    // clock generator start and self lock
    host_inst.wr(`GCL_IDX_CLK, 8'h80);
    chk(8'({run, valid}), 8'h02);
    host_inst.wait_valid(ok);
    chk(8'(ok), 8'h01);
    host_inst.wr(`GCL_IDX_CLK, 8'h00);
    chk_reg(`GCL_IDX_CLK, 8'h90);
    // a second reset clears every lock
    do_reset();
    chk_reg(`GCL_IDX_CFG1, 8'h11);
    chk_reg(`GCL_IDX_FDIS, 8'h00);
    chk(8'({plock, run, valid}), 8'h00);
    // mux lock alone: global enable stays writable, wait field does not
    host_inst.wr(`GCL_IDX_CFG1, 8'h81);
    host_inst.wr(`GCL_IDX_CFG1, 8'h0c);
    chk_reg(`GCL_IDX_CFG1, 8'h90);
    chk(8'({io_wait, den}), 8'h00);
    give_verdict();
  end
endmodule : global_config_lock_regs_bench
`default_nettype wire
